// File: rtl/mtu_pkg.sv
// Package of constants and types for the memory timing unit.
package mtu_pkg;
  localparam int unsigned CLK_PERIOD_PS     = 4000;
  localparam int unsigned CLR_PULSE_NS      = 50;
  localparam int unsigned WIN_NS            = 200;
  localparam int unsigned SET_PULSE_NS      = 50;
  localparam int unsigned RD_DONE_NS        = 125;
  localparam int unsigned RESP_TMO_NS       = 100;
  localparam int unsigned MCLR_NS           = 200;
  localparam int unsigned CLR_PULSE_CYC     = (CLR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WIN_CYC           = (WIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SET_PULSE_CYC     = (SET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RD_DONE_CYC       = (RD_DONE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RESP_TMO_CYC      = (RESP_TMO_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MCLR_CYC          = (MCLR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TMR_W             = 6;
  localparam int unsigned NUM_DEV           = 4;
  localparam int unsigned PAR_W             = 4;
  localparam int unsigned SYNC_W            = 12;
  localparam logic [1:0]  DIR_DSP           = 2'h3;
  localparam logic [1:0]  DIR_RAR           = 2'h2;
  localparam logic [1:0]  DIR_WAR           = 2'h0;
  localparam logic [1:0]  DIR_IDLE          = 2'h0;
  typedef logic [TMR_W-1:0] mtu_cnt_t;
  typedef enum logic [1:0] {
    MTU_WR_IDLE = 2'h0,
    MTU_WR_WIN  = 2'h1,
    MTU_WR_SET  = 2'h3
  } mtu_wr_e;
endpackage

// File: rtl/mtu_tmr_if.sv
// Interface carrying one one-shot timer's trigger, load value and outputs.
`timescale 1ns/100ps
interface mtu_tmr_if;
  import mtu_pkg::*;
  logic     fire;
  mtu_cnt_t len;
  logic     busy;
  logic     done;
  modport owner (output fire, output len, input busy, input done);
  modport timer (input fire, input len, output busy, output done);
endinterface

// File: rtl/mtu_oneshot.sv
// Retriggerable one-shot counter with an end-of-interval pulse.
`timescale 1ns/100ps
module mtu_oneshot
  import mtu_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  // Timer link.
  mtu_tmr_if.timer t
);
  mtu_cnt_t cnt_q;
  logic     done_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
    end else if (t.fire) begin
      cnt_q <= t.len;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - mtu_cnt_t'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= !clr && !t.fire && (cnt_q == mtu_cnt_t'(1));
    end
  end

  assign t.busy = (cnt_q != '0);
  assign t.done = done_q;
endmodule

// File: rtl/mtu_memory_timing_unit.sv
// Memory timing unit: request handshake, buffer control, parity, flags and write arbiter.
`timescale 1ns/100ps
module mtu_memory_timing_unit
  import mtu_pkg::*;
(
  // Clock and reset.
  input  wire logic                            mclk,
  input  wire logic                            rst,
  // Configuration.
  input  wire logic                            translator_mode,
  // Processor side.
  input  wire logic                            cycle_flag,
  input  wire logic                            stack_write,
  input  wire logic                            data_write,
  input  wire logic                            push_to_buffer,
  input  wire logic                            proc_paused,
  input  wire logic                            clear_host_flag,
  input  wire logic                            parity_ignore_in,
  input  wire logic [mtu_pkg::PAR_W-1:0]       buffer_parity,
  output logic                                 ack_flag,
  output logic                                 buffer_load_n,
  output logic                                 stack_push_load_n,
  output logic                                 buffer_clear_pulse_n,
  output logic                                 buffer_set_pulse_n,
  output logic                                 host_bus_load_n,
  output logic                                 host_loaded_flag,
  output logic                                 parity_error,
  output logic                                 parity_alarm,
  // Mapper side.
  input  wire logic                            mapper_ok,
  input  wire logic                            mapper_request,
  output logic                                 mapper_go,
  output logic                                 mapper_fast_clear,
  output logic                                 translator_cycle_done_n,
  // Memory interface side.
  input  wire logic                            request_accepted_echo,
  input  wire logic                            write_complete_pulse,
  input  wire logic                            read_restart_strobe_n,
  input  wire logic                            incoming_parity_bit,
  input  wire logic                            address_acknowledged,
  output logic                                 memory_request_n,
  output logic                                 mem_read,
  output logic                                 mem_write,
  output logic                                 outgoing_parity_bit,
  output logic                                 multiplexer_clear,
  output logic                                 nonexistent_memory_flag,
  // Host commands and master clear.
  input  wire logic                            host_clear_buffer_cmd,
  input  wire logic                            host_set_buffer_cmd,
  input  wire logic                            host_master_clear,
  input  wire logic                            panel_master_clear,
  output logic                                 master_clear,
  output logic                                 master_clear_n,
  // Write devices.
  input  wire logic [mtu_pkg::NUM_DEV-1:0]     dev_request,
  input  wire logic [2*mtu_pkg::NUM_DEV-1:0]   dev_directive,
  input  wire logic                            write_buffer_taken,
  output logic [mtu_pkg::NUM_DEV-1:0]          dev_data_grant_n,
  output logic [mtu_pkg::NUM_DEV-1:0]          dev_ack,
  output logic                                 write_buffer_occupied,
  output logic                                 write_buffer_load_n,
  output logic                                 directive_bit_hi,
  output logic                                 directive_bit_hi_oe,
  output logic                                 directive_bit_lo,
  output logic                                 directive_bit_lo_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers.
  // two-stage synchronisers
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] async_in;
  logic [NUM_DEV-1:0] dreq_s1_q;
  logic [NUM_DEV-1:0] dreq_q;

  assign async_in = {mapper_ok, mapper_request, request_accepted_echo, write_complete_pulse,
                     read_restart_strobe_n, incoming_parity_bit, address_acknowledged,
                     host_clear_buffer_cmd, host_set_buffer_cmd, host_master_clear,
                     panel_master_clear, write_buffer_taken};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Reset to each pin's idle level so no false edge follows reset; the read strobe rests high.
      s1_q      <= 12'h080;
      s2_q      <= 12'h080;
      s3_q      <= 12'h080;
      dreq_s1_q <= '0;
      dreq_q    <= '0;
    end else begin
      s1_q      <= async_in;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      dreq_s1_q <= dev_request;
      dreq_q    <= dreq_s1_q;
    end
  end

  logic ok_s, mreq_s, echo_s, wrc_s, rdrs_n_s, rpar_s, ackd_s, hclr_s, hset_s, hmc_s, pmc_s, wbt_s;
  assign {ok_s, mreq_s, echo_s, wrc_s, rdrs_n_s, rpar_s, ackd_s, hclr_s, hset_s, hmc_s, pmc_s, wbt_s} = s2_q;
  logic echo_rise, echo_fall, wrc_rise, rdrs_fall, hclr_rise, hset_rise, mc_rise;
  assign echo_rise = echo_s && !s3_q[9];
  assign echo_fall = !echo_s && s3_q[9];
  assign wrc_rise  = wrc_s && !s3_q[8];
  assign rdrs_fall = !rdrs_n_s && s3_q[7];
  assign hclr_rise = hclr_s && !s3_q[4];
  assign hset_rise = hset_s && !s3_q[3];
  assign mc_rise   = (hmc_s && !s3_q[2]) || (pmc_s && !s3_q[1]);

  ////////////////////////////////////////////////////////////////////////////////
  // One-shot timers.
  logic mclr;
  mtu_tmr_if mc_t ();
  mtu_tmr_if rd_t ();
  mtu_tmr_if to_t ();
  assign mc_t.fire = mc_rise;
  assign mc_t.len  = mtu_cnt_t'(MCLR_CYC);
  assign mclr      = mc_t.busy;
  mtu_oneshot u_mc (.mclk(mclk), .rst(rst), .clr(1'b0), .t(mc_t));
  assign rd_t.fire = rdrs_fall;
  assign rd_t.len  = mtu_cnt_t'(RD_DONE_CYC);
  mtu_oneshot u_rd (.mclk(mclk), .rst(rst), .clr(mclr), .t(rd_t));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      master_clear   <= 1'b0;
      master_clear_n <= 1'b1;
    end else begin
      master_clear   <= mclr;
      master_clear_n <= !mclr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Access request flip-flops.
  logic cyc_q, pend_q, preq_q, ready_q, preq_rise;
  logic is_write;
  assign is_write = preq_q && (stack_write || data_write);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cyc_q <= 1'b0;
    end else begin
      cyc_q <= cycle_flag;
    end
  end

  // pending set on cycle flag rise; cleared by request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (mclr) begin
      pend_q <= 1'b0;
    end else if (cycle_flag && !cyc_q) begin
      pend_q <= 1'b1;
    end else if (preq_q) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      preq_q <= 1'b0;
    end else if (mclr) begin
      preq_q <= 1'b0;
    end else if (pend_q && (!translator_mode || ok_s)) begin
      preq_q <= 1'b1;
    end else if (echo_fall && !translator_mode) begin
      preq_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ready_q <= 1'b1;
    end else if (mclr) begin
      ready_q <= 1'b1;
    end else if (echo_s) begin
      ready_q <= 1'b0;
    end else if (echo_fall && !translator_mode) begin
      ready_q <= 1'b1;
    end
  end

  logic preq_d1_q;
  assign preq_rise = preq_q && !preq_d1_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      preq_d1_q         <= 1'b0;
      memory_request_n  <= 1'b1;
      mem_read          <= 1'b1;
      mem_write         <= 1'b0;
      mapper_go         <= 1'b0;
      mapper_fast_clear <= 1'b0;
    end else begin
      preq_d1_q         <= preq_q;
      memory_request_n  <= !(ready_q && !echo_s && (preq_q || (mreq_s && translator_mode)));
      mem_read          <= !is_write;
      mem_write         <= is_write;
      mapper_go         <= translator_mode && pend_q && !mclr;
      mapper_fast_clear <= translator_mode && echo_fall;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer control sequencing.
  mtu_wr_e  wst_q;
  mtu_cnt_t wcnt_q;
  mtu_cnt_t clr_cnt_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wst_q  <= MTU_WR_IDLE;
      wcnt_q <= '0;
    end else if (mclr) begin
      wst_q  <= MTU_WR_IDLE;
      wcnt_q <= '0;
    end else begin
      case (wst_q)
        MTU_WR_IDLE: begin
          if (preq_rise && (stack_write || data_write)) begin
            wst_q  <= MTU_WR_WIN;
            wcnt_q <= mtu_cnt_t'(WIN_CYC - 1);
          end
        end
        MTU_WR_WIN: begin
          if (wcnt_q == '0) begin
            wst_q  <= MTU_WR_SET;
            wcnt_q <= mtu_cnt_t'(SET_PULSE_CYC - 1);
          end else begin
            wcnt_q <= wcnt_q - mtu_cnt_t'(1);
          end
        end
        MTU_WR_SET: begin
          if (wcnt_q == '0) begin
            wst_q <= MTU_WR_IDLE;
          end else begin
            wcnt_q <= wcnt_q - mtu_cnt_t'(1);
          end
        end
        default: begin
          wst_q <= MTU_WR_IDLE;
        end
      endcase
    end
  end

  // read clear pulse on echo rise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clr_cnt_q <= '0;
    end else if (echo_rise && !is_write) begin
      clr_cnt_q <= mtu_cnt_t'(CLR_PULSE_CYC);
    end else if (clr_cnt_q != '0) begin
      clr_cnt_q <= clr_cnt_q - mtu_cnt_t'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buffer_load_n        <= 1'b1;
      stack_push_load_n    <= 1'b1;
      buffer_clear_pulse_n <= 1'b1;
      buffer_set_pulse_n   <= 1'b1;
      host_bus_load_n      <= 1'b1;
      host_loaded_flag     <= 1'b0;
    end else begin
      buffer_load_n        <= !(wst_q == MTU_WR_WIN && data_write);
      stack_push_load_n    <= !(wst_q == MTU_WR_WIN && push_to_buffer);
      buffer_clear_pulse_n <= !(clr_cnt_q != '0);
      buffer_set_pulse_n   <= !(wst_q == MTU_WR_SET || (hclr_rise && proc_paused));
      host_bus_load_n      <= !(hset_rise && proc_paused);
      if (mclr) begin
        host_loaded_flag <= 1'b0;
      end else if (hset_rise && proc_paused) begin
        host_loaded_flag <= 1'b1;
      end else if (clear_host_flag) begin
        host_loaded_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parity.
  logic rpar_q, ign_q, par_even, par_fault;
  assign par_even  = ~^buffer_parity;
  assign par_fault = (rpar_q != par_even) && !ign_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rpar_q <= 1'b0;
      ign_q  <= 1'b0;
    end else if (mclr) begin
      rpar_q <= 1'b0;
      ign_q  <= 1'b0;
    end else begin
      if (echo_s && !is_write) begin
        rpar_q <= rpar_s;
      end
      if (parity_ignore_in) begin
        ign_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outgoing_parity_bit     <= 1'b0;
      parity_error            <= 1'b0;
      parity_alarm            <= 1'b0;
      translator_cycle_done_n <= 1'b1;
      ack_flag                <= 1'b0;
    end else begin
      outgoing_parity_bit     <= is_write ? par_even : 1'b0;
      parity_error            <= !is_write && preq_q && par_fault;
      translator_cycle_done_n <= !(rd_t.done && !par_fault && translator_mode);
      if (mclr) begin
        parity_alarm <= 1'b0;
        ack_flag     <= 1'b0;
      end else begin
        if (rd_t.done && par_fault) begin
          parity_alarm <= 1'b1;
        end
        if (wrc_rise || (rd_t.done && !par_fault && !translator_mode)) begin
          ack_flag <= 1'b1;
        end else if (!cycle_flag) begin
          ack_flag <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Response timeout.
  // 100 ns timer restarted per request
  assign to_t.fire = (!memory_request_n && !to_t.busy) || multiplexer_clear;
  assign to_t.len  = mtu_cnt_t'(RESP_TMO_CYC);
  mtu_oneshot u_to (.mclk(mclk), .rst(rst), .clr(mclr), .t(to_t));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      multiplexer_clear       <= 1'b0;
      nonexistent_memory_flag <= 1'b0;
    end else if (mclr) begin
      multiplexer_clear       <= 1'b0;
      nonexistent_memory_flag <= 1'b0;
    end else begin
      multiplexer_clear <= to_t.done && echo_s && !ackd_s;
      if (to_t.done && echo_s && ackd_s) begin
        nonexistent_memory_flag <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write arbiter.
  logic [NUM_DEV-1:0] mst_q, slv_q, win;
  logic               busy_q;

  function automatic logic [NUM_DEV-1:0] mtu_prio(input logic [NUM_DEV-1:0] r);
    logic [NUM_DEV-1:0] g;
    logic               taken;
    g     = '0;
    taken = 1'b0;
    for (int i = 0; i < NUM_DEV; i++) begin
      g[i]  = r[i] && !taken;
      taken = taken || r[i];
    end
    return g;
  endfunction

  assign win = mtu_prio(slv_q);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mst_q  <= '0;
      slv_q  <= '0;
      busy_q <= 1'b0;
    end else if (mclr) begin
      mst_q  <= '0;
      slv_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      if (!busy_q || wbt_s) begin
        mst_q  <= dreq_q;
        busy_q <= |dreq_q;
      end
      slv_q <= mst_q;
    end
  end

  // occupied flag, grants, directives and acknowledge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      write_buffer_occupied <= 1'b0;
      write_buffer_load_n   <= 1'b1;
      dev_data_grant_n      <= '1;
      dev_ack               <= '0;
      directive_bit_hi      <= 1'b0;
      directive_bit_lo      <= 1'b0;
      directive_bit_hi_oe   <= 1'b0;
      directive_bit_lo_oe   <= 1'b0;
    end else if (mclr) begin
      write_buffer_occupied <= 1'b0;
      write_buffer_load_n   <= 1'b1;
      dev_data_grant_n      <= '1;
      dev_ack               <= '0;
      directive_bit_hi_oe   <= 1'b0;
      directive_bit_lo_oe   <= 1'b0;
    end else begin
      write_buffer_occupied <= |win;
      write_buffer_load_n   <= !write_buffer_occupied;
      dev_data_grant_n      <= ~win;
      dev_ack               <= (!write_buffer_load_n) ? ~dev_data_grant_n : '0;
      directive_bit_hi      <= 1'b0;
      directive_bit_lo      <= 1'b0;
      directive_bit_hi_oe   <= 1'b0;
      directive_bit_lo_oe   <= 1'b0;
      for (int i = 0; i < NUM_DEV; i++) begin
        if (win[i]) begin
          directive_bit_hi_oe <= !dev_directive[2*i+1];
          directive_bit_lo_oe <= !dev_directive[2*i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  AST_REQ_READY: assert property (@(posedge mclk) disable iff (rst)
    !memory_request_n |-> $past(ready_q)) else $error("Request driven while not ready.");
  AST_ECHO_RELEASE: assert property (@(posedge mclk) disable iff (rst)
    echo_s |=> memory_request_n) else $error("Request not released on echo.");
  AST_DIRECT_REQ: assert property (@(posedge mclk) disable iff (rst || mclr)
    (pend_q && !translator_mode) |=> preq_q) else $error("Direct mode request not set.");
  AST_PEND_CLR: assert property (@(posedge mclk) disable iff (rst || mclr)
    (preq_q && $past(preq_q) && !(cycle_flag && !cyc_q)) |=> !pend_q) else $error("Pending not cleared.");
  AST_RW_SEL: assert property (@(posedge mclk) disable iff (rst)
    !preq_q |=> mem_read && !mem_write) else $error("Write without processor request.");
  AST_ACK_WRC: assert property (@(posedge mclk) disable iff (rst || mclr)
    wrc_rise |=> ack_flag) else $error("Write completion did not acknowledge.");
  AST_NXM_STICKY: assert property (@(posedge mclk) disable iff (rst || mclr)
    nonexistent_memory_flag |=> nonexistent_memory_flag) else $error("Nonexistent memory flag dropped.");
  AST_GRANT_ONEHOT: assert property (@(posedge mclk) disable iff (rst)
    $onehot0(~dev_data_grant_n)) else $error("More than one grant.");
  AST_RD_DONE: assert property (@(posedge mclk) disable iff (rst || mclr)
    rdrs_fall ##1 !rdrs_fall [*1] |-> ##32 rd_t.done) else $error("Read done timing wrong.");
endmodule

// File: test/mtu_mem_model.sv
// Memory interface and mapper model facing the memory timing unit.
`timescale 1ns/100ps
module mtu_mem_model (
  input  wire logic mclk,
  input  wire logic req_n,
  input  wire logic wr,
  input  wire logic go,
  input  wire logic slow,
  output logic      echo,
  output logic      wdone,
  output logic      rstb_n,
  output logic      ok
);
  logic was_wr;

  initial begin
    {echo, wdone, ok, rstb_n} = 4'h1;
    was_wr = 1'b0;
    forever begin
      @(posedge mclk);
      ok <= go && req_n;
      if (!req_n) begin
        // The direction is kept here, because the unit drops it once the echo falls.
        was_wr = wr;
        echo <= 1'b1;
        while (!req_n) @(posedge mclk);
        // A slow memory keeps its echo up past the unit's response timer.
        repeat (slow ? 60 : 3) @(posedge mclk);
        echo <= 1'b0;
        repeat (6) @(posedge mclk);
        // completion strobes
        // Strobes are held three cycles so the synchroniser cannot miss them.
        wdone <= was_wr;
        rstb_n <= was_wr;
        repeat (3) @(posedge mclk);
        wdone <= 1'b0;
        rstb_n <= 1'b1;
      end
    end
  end
endmodule

// File: test/memory_access_timing_control_test.sv
// Self-checking bench for the memory timing unit.
`timescale 1ns/100ps
module memory_access_timing_control_test;
  import mtu_pkg::*;
  logic mclk, rst, translator_mode, cycle_flag, stack_write, data_write, push_to_buffer;
  logic proc_paused, clear_host_flag, parity_ignore_in, mapper_ok, mapper_request;
  logic request_accepted_echo, write_complete_pulse, read_restart_strobe_n, incoming_parity_bit;
  logic address_acknowledged, host_clear_buffer_cmd, host_set_buffer_cmd, host_master_clear;
  logic panel_master_clear, write_buffer_taken, ack_flag, buffer_load_n, stack_push_load_n;
  logic buffer_clear_pulse_n, buffer_set_pulse_n, host_bus_load_n, host_loaded_flag, parity_error;
  logic parity_alarm, mapper_go, mapper_fast_clear, translator_cycle_done_n, memory_request_n;
  logic mem_read, mem_write, outgoing_parity_bit, multiplexer_clear, nonexistent_memory_flag;
  logic master_clear, master_clear_n, write_buffer_occupied, write_buffer_load_n;
  logic directive_bit_hi, directive_bit_hi_oe, directive_bit_lo, directive_bit_lo_oe, wr, sw, pu, slow;
  logic [PAR_W-1:0]     buffer_parity;
  logic [NUM_DEV-1:0]   dev_request, dev_data_grant_n, dev_ack;
  logic [2*NUM_DEV-1:0] dev_directive;
  int err_count, num_checks, i, seed, lo, ld;
  int q[$];
  mtu_memory_timing_unit i_dut (.*);
  mtu_mem_model i_mem (.mclk(mclk), .req_n(memory_request_n), .wr(mem_write), .go(mapper_go), .slow(slow),
    .echo(request_accepted_echo), .wdone(write_complete_pulse), .rstb_n(read_restart_strobe_n), .ok(mapper_ok));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (e !== g) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
  initial begin
    seed = 32'h367ee3f9;
    {translator_mode, cycle_flag, stack_write, data_write, push_to_buffer, proc_paused} = '0;
    {clear_host_flag, mapper_request, incoming_parity_bit, host_clear_buffer_cmd} = '0;
    {host_set_buffer_cmd, host_master_clear, panel_master_clear, write_buffer_taken, slow} = '0;
    {buffer_parity, dev_request, dev_directive} = '0;
    // Parity faults would withhold the acknowledge, so they are ignored here.
    parity_ignore_in = 1'b1;
    address_acknowledged = 1'b1;
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("req_n", 1, memory_request_n);
    chk("grant", 4'hf, dev_data_grant_n);
    repeat (6) begin
      repeat (4) @(posedge mclk);
      wr = 1'($random(seed));
      sw = 1'($random(seed));
      pu = 1'($random(seed));
      q.push_back(wr | sw);
      data_write <= wr;
      stack_write <= sw;
      push_to_buffer <= pu;
      buffer_parity <= 4'($random(seed));
      cycle_flag <= 1'b1;
      for (i = 0; i < 99 && memory_request_n !== 1'b0; i++) @(negedge mclk);
      chk("req_n", 0, memory_request_n);
      chk("write", q[0], mem_write);
      if (q[0]) chk("wpar", ~^buffer_parity, outgoing_parity_bit);
      lo = 0;
      ld = 0;
      for (i = 0; i < 80; i++) begin
        @(negedge mclk);
        lo += q[0] ? !buffer_set_pulse_n : !buffer_clear_pulse_n;
        ld += !buffer_load_n + !stack_push_load_n;
      end
      chk("ack", 1, ack_flag);
      chk("pulse", q[0] ? SET_PULSE_CYC : CLR_PULSE_CYC, lo);
      chk("loads", q[0] ? WIN_CYC * (wr + pu) : 0, ld);
      void'(q.pop_front());
      @(posedge mclk) cycle_flag <= 1'b0;
      {data_write, stack_write} <= 2'h0;
    end
    // Memory that holds its echo: a retry first, then the nonexistent-memory flag.
    slow <= 1'b1;
    address_acknowledged <= 1'b0;
    @(posedge mclk) cycle_flag <= 1'b1;
    lo = 0;
    for (i = 0; i < 44; i++) begin
      @(negedge mclk);
      lo += multiplexer_clear;
    end
    chk("mpx", 1, lo);
    chk("nxm", 0, nonexistent_memory_flag);
    @(posedge mclk) address_acknowledged <= 1'b1;
    slow <= 1'b0;
    repeat (80) @(negedge mclk);
    chk("nxm", 1, nonexistent_memory_flag);
    @(posedge mclk) cycle_flag <= 1'b0;
    translator_mode <= 1'b1;
    @(posedge mclk) cycle_flag <= 1'b1;
    for (i = 0; i < 99 && mapper_go !== 1'b1; i++) @(negedge mclk);
    chk("go", 1, mapper_go);
    lo = 0;
    ld = 0;
    for (i = 0; i < 150; i++) begin
      @(negedge mclk);
      lo += !translator_cycle_done_n;
      ld += mapper_fast_clear;
    end
    chk("done_n", 1, lo);
    chk("fclr", 1, ld);
    @(posedge mclk) host_master_clear <= 1'b1;
    repeat (4) @(posedge mclk);
    {host_master_clear, cycle_flag, translator_mode} <= 3'h0;
    @(negedge mclk);
    chk("mclr", 2'h2, {master_clear, master_clear_n});
    repeat (60) @(negedge mclk);
    chk("mclr", 2'h1, {master_clear, master_clear_n});
    chk("req_n", 1, memory_request_n);
    chk("nxm", 0, nonexistent_memory_flag);
    for (i = 0; i < 2; i++) begin
      @(posedge mclk) proc_paused <= i[0];
      {host_set_buffer_cmd, host_clear_buffer_cmd} <= 2'h3;
      lo = 0;
      repeat (6) begin
        @(negedge mclk);
        lo += !host_bus_load_n + !buffer_set_pulse_n;
      end
      chk("host", i, host_loaded_flag);
      chk("hpulse", 2 * i, lo);
      @(posedge mclk) {host_set_buffer_cmd, host_clear_buffer_cmd} <= 2'h0;
    end
    @(posedge mclk) clear_host_flag <= 1'b1;
    @(posedge mclk) clear_host_flag <= 1'b0;
    @(negedge mclk);
    chk("hflag", 0, host_loaded_flag);
    @(posedge mclk) dev_request <= 4'h6;
    dev_directive <= 8'($random(seed));
    for (i = 0; i < 20 && write_buffer_occupied !== 1'b1; i++) @(negedge mclk);
    chk("full", 1, write_buffer_occupied);
    chk("grants", 1, $countones(~dev_data_grant_n));
    chk("grant", 4'hd, dev_data_grant_n);
    chk("lone", 0, 4'(~dev_data_grant_n & ~dev_request));
    repeat (2) @(negedge mclk);
    chk("wload_n", 0, write_buffer_load_n);
    chk("dack", 4'h2, dev_ack);
    chk("dir", 2'(~dev_directive[3:2]), {directive_bit_hi_oe, directive_bit_lo_oe});
    stop_test();
  end
endmodule
